/* File: verilog/rsc_pkg.sv */
// Package of constants for the rheostat serial command block
package rsc_pkg;

  // Frame layout
  localparam int FRAME_W = 16; // Bits per frame
  localparam int CMD_W = 4; // Command code width
  localparam int DATA_W = 10; // Wiper data width
  localparam int CMD_LSB = 10; // Command code position
  localparam int CNT_W = 4; // Bit counter, modulo one frame
  localparam int FADDR_W = 6; // Fuse location address width
  localparam int FUSE_DEPTH = 50; // Fuse locations
  localparam int SHORT_DROP = 2; // Low bits ignored, 256 variant

  // Command codes
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_WR_WIPER = 4'h1;
  localparam logic [3:0] CMD_RD_WIPER = 4'h2;
  localparam logic [3:0] CMD_STORE = 4'h3;
  localparam logic [3:0] CMD_SW_RESET = 4'h4;
  localparam logic [3:0] CMD_RD_FUSE = 4'h5;
  localparam logic [3:0] CMD_RD_ADDR = 4'h6;
  localparam logic [3:0] CMD_WR_CTRL = 4'h7;
  localparam logic [3:0] CMD_RD_CTRL = 4'h8;
  localparam logic [3:0] CMD_SHUTDOWN = 4'h9;

  // Control register bits
  localparam int CTL_W = 4;
  localparam int CTL_PROG = 0; // fuse_program_enable
  localparam int CTL_UNLOCK = 1; // wiper_write_unlock
  localparam int CTL_TOL = 2; // tolerance_calibration_off
  localparam int CTL_OK = 3; // fuse_program_ok
  localparam int CTL_WR_W = 3; // Bits written by command 7
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [9:0] MIDSCALE = 10'h200;

  // Fuse store time
  localparam int STORE_TIME_MS = 350;
  localparam int CLK_HZ = 10_000_000;
  localparam int STORE_CYCLES = STORE_TIME_MS * (CLK_HZ / 1000);

  // APB map
  localparam int PADDR_W = 12;
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_WIPER = 12'h004;
  localparam logic [11:0] OFS_LINK = 12'h008;
  localparam logic [11:0] OFS_FRAME = 12'h00c;
  // Status and link fields
  localparam int ST_ADDR_LSB = 4;
  localparam int ST_SHDN = 10;
  localparam int ST_BUSY = 11;
  localparam int LINK_EN_BIT = 0;
  localparam logic LINK_EN_RST = 1'b1;

endpackage

/* File: verilog/rsc_top.sv */
// Serial command interpreter with fuse wiper store and APB access
// Overview of operation
// - Frame is 16 bits, MSB first, command, data
// - Short variant ignores two low data bits of a wiper write
// - Select rise decodes word, loads register
// - Only whole multiples of 16 bits accepted
// - Idle or irregular clock while deselected safe
// - Wiper register sets wiper, unlimited rewrites
// - Command 1 writes wiper when unlocked
// - Command 2 returns wiper next frame
// - Command 3 stores wiper to next fuse
// - Store busy period locks shift register
// - Success bit reports completed fuse store
// - Power-up loads midscale; reset also clears the fuse array
// - Unlock clear after reset blocks wiper writes
// - Command 7 writes control bits 2 to 0
// - Command 4 reloads wiper from last fuse
// - Command 5 reads selected fuse next frame
// - Command 6 returns last fuse address
// - Command 8 returns control register
// - Command 9 bit 0 sets shutdown
// - Data sampled on serial clock falling edge
// - Short frame discarded, registers unchanged
// - Unlock bit gates command 1 wiper writes
module rsc_top #(
  parameter int STORE_CYCLES = rsc_pkg::STORE_CYCLES,
  parameter bit SHORT_VARIANT = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic din,
  output logic serial_out,
  output logic serial_out_oe,
  output logic [9:0] wiper_position,
  output logic shutdown,
  output logic tolerance_calibration_off
);

  localparam int BW = $clog2(STORE_CYCLES + 1); // Busy counter width
  localparam logic [BW-1:0] BUSY_LOAD = BW'(STORE_CYCLES);
  localparam logic [BW-1:0] BUSY_ONE = BW'(1);
  localparam int FW = rsc_pkg::FRAME_W;
  localparam int DW = rsc_pkg::DATA_W;
  localparam int AW = rsc_pkg::FADDR_W;

  // Pin synchronisers: select, clock, data
  logic [2:0] pin_s1_reg; // First stage, read only by second
  logic [2:0] pin_s2_reg;
  logic [2:0] pin_s3_reg;
  logic [2:0] pin_reg; // Filtered pin levels
  logic [2:0] pin_next;
  logic [2:0] pin_eq; // Stages two and three agree

  // Frame state
  logic [FW-1:0] shift_reg; // Incoming word
  logic [rsc_pkg::CNT_W-1:0] bit_cnt_reg; // Bits modulo 16
  logic seen16_reg; // At least one full frame clocked
  logic frame_valid_reg; // Frame accepted at select fall
  logic [FW-1:0] out_reg; // Outgoing word
  logic [FW-1:0] pend_reg; // Word for the next frame
  logic [FW-1:0] last_frame_reg; // Last decoded word

  // Device state
  logic [DW-1:0] wiper_reg;
  logic [rsc_pkg::CTL_W-1:0] ctrl_reg;
  logic shdn_reg;
  logic [AW-1:0] fuse_cnt_reg; // Last programmed location
  logic [DW-1:0] fuse_mem [0:rsc_pkg::FUSE_DEPTH];
  logic [BW-1:0] busy_cnt_reg;
  logic restore_reg; // Power-up restore pending
  logic link_en_reg; // Software gate for the serial link

  // APB outputs and serial output enable
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic so_oe_reg;

  // Stable level once stages two and three agree
  assign pin_eq = ~(pin_s2_reg ^ pin_s3_reg);
  assign pin_next = (pin_eq & pin_s3_reg) | (~pin_eq & pin_reg);

  // Edge events on the filtered levels
  wire sel_fall = pin_reg[2] & ~pin_next[2];
  wire sel_rise = ~pin_reg[2] & pin_next[2];
  wire sclk_fall = pin_reg[1] & ~pin_next[1];
  wire busy = busy_cnt_reg != '0;
  // Clock edges only count inside an accepted frame
  wire in_frame = frame_valid_reg & ~pin_reg[2];
  wire shift_en = in_frame & sclk_fall;

  // Frame complete only on whole multiples of 16 bits
  wire frame_ok = sel_rise & frame_valid_reg & seen16_reg
    & (bit_cnt_reg == '0);

  // Decode of the captured word, top two bits unused
  wire [rsc_pkg::CMD_W-1:0] cmd = shift_reg[rsc_pkg::CMD_LSB +:
    rsc_pkg::CMD_W];
  wire [DW-1:0] data = shift_reg[DW-1:0];
  wire [DW-1:0] drop_mask = SHORT_VARIANT ?
    ~DW'((1 << rsc_pkg::SHORT_DROP) - 1) : '1;
  wire [DW-1:0] wr_data = data & drop_mask;
  wire [AW-1:0] rd_addr = data[AW-1:0];
  wire full = fuse_cnt_reg == AW'(rsc_pkg::FUSE_DEPTH);
  wire [AW-1:0] next_addr = fuse_cnt_reg + AW'(1);
  // Location 0 is reserved and reads as zero
  wire rd_in_range = (rd_addr != '0) &&
    (rd_addr <= AW'(rsc_pkg::FUSE_DEPTH));
  wire [DW-1:0] fuse_rd = rd_in_range ? fuse_mem[rd_addr] : '0;
  wire [DW-1:0] stored_val = (fuse_cnt_reg == '0) ?
    rsc_pkg::MIDSCALE : fuse_mem[fuse_cnt_reg];

  // Command strobes
  wire do_wr = frame_ok & (cmd == rsc_pkg::CMD_WR_WIPER)
    & ctrl_reg[rsc_pkg::CTL_UNLOCK];
  wire do_reset = frame_ok & (cmd == rsc_pkg::CMD_SW_RESET);
  wire do_store = frame_ok & (cmd == rsc_pkg::CMD_STORE)
    & ctrl_reg[rsc_pkg::CTL_PROG] & ~full;
  wire do_ctrl = frame_ok & (cmd == rsc_pkg::CMD_WR_CTRL);
  wire do_shdn = frame_ok & (cmd == rsc_pkg::CMD_SHUTDOWN);
  wire store_done = busy_cnt_reg == BUSY_ONE;

  // Readback word for the next frame, echo by default
  logic [FW-1:0] pend_next;
  always_comb
  begin
    case (cmd)
      rsc_pkg::CMD_RD_WIPER: pend_next = FW'(wiper_reg);
      rsc_pkg::CMD_RD_FUSE: pend_next = FW'(fuse_rd);
      rsc_pkg::CMD_RD_ADDR: pend_next = FW'(fuse_cnt_reg);
      rsc_pkg::CMD_RD_CTRL: pend_next = FW'(ctrl_reg);
      default: pend_next = shift_reg;
    endcase
  end

  // APB decode
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pready_reg & pwrite;
  wire hit_status = paddr == rsc_pkg::OFS_STATUS;
  wire hit_wiper = paddr == rsc_pkg::OFS_WIPER;
  wire hit_link = paddr == rsc_pkg::OFS_LINK;
  wire hit_frame = paddr == rsc_pkg::OFS_FRAME;
  wire hit_any = hit_status | hit_wiper | hit_link | hit_frame;
  wire [31:0] status_word = 32'(ctrl_reg)
    | (32'(fuse_cnt_reg) << rsc_pkg::ST_ADDR_LSB)
    | (32'(shdn_reg) << rsc_pkg::ST_SHDN)
    | (32'(busy) << rsc_pkg::ST_BUSY);
  wire [31:0] rd_mux = hit_status ? status_word :
    hit_wiper ? 32'(wiper_reg) :
    hit_link ? 32'(link_en_reg) :
    hit_frame ? 32'(last_frame_reg) : 32'h0000_0000;

  // Pin synchroniser chain
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pin_s1_reg <= 3'h7;
      pin_s2_reg <= 3'h7;
      pin_s3_reg <= 3'h7;
      pin_reg <= 3'h7;
    end
    else if (clk_en)
    begin
      pin_s1_reg <= {sync_n, sclk, din};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_reg <= pin_next;
    end
  end

  // Frame acceptance; lock out frames while a store runs
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      frame_valid_reg <= 1'b0;
    else if (clk_en)
    begin
      if (do_store)
        frame_valid_reg <= 1'b0;
      else if (sel_fall)
        frame_valid_reg <= link_en_reg & ~busy;
      else if (sel_rise)
        frame_valid_reg <= 1'b0;
    end
  end

  // Input shifter and bit counter
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      shift_reg <= '0;
      bit_cnt_reg <= '0;
      seen16_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (sel_fall)
      begin
        bit_cnt_reg <= '0;
        seen16_reg <= 1'b0;
      end
      else if (shift_en)
      begin
        // MSB arrives first and ends at bit 15
        shift_reg <= {shift_reg[FW-2:0], pin_reg[0]};
        bit_cnt_reg <= bit_cnt_reg + 1'b1;
        if (bit_cnt_reg == '1)
          seen16_reg <= 1'b1;
      end
    end
  end

  // Output shifter; open drain, pulls low for zero bits
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      out_reg <= '0;
      so_oe_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (sel_fall)
        out_reg <= pend_reg;
      else if (shift_en)
        out_reg <= {out_reg[FW-2:0], 1'b0};
      so_oe_reg <= in_frame & ~out_reg[FW-1];
    end
  end

  // Readback word and frame log
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pend_reg <= '0;
      last_frame_reg <= '0;
    end
    else if (clk_en && frame_ok)
    begin
      pend_reg <= pend_next;
      last_frame_reg <= shift_reg;
    end
  end

  // Wiper register; restore after reset, then commands
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wiper_reg <= rsc_pkg::MIDSCALE;
      restore_reg <= 1'b1;
    end
    else if (clk_en)
    begin
      restore_reg <= 1'b0;
      if (restore_reg || do_reset)
        wiper_reg <= stored_val;
      else if (do_wr)
        wiper_reg <= wr_data;
    end
  end

  // Control register; success bit set by the store engine
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      ctrl_reg <= rsc_pkg::CTRL_RST;
    else if (clk_en)
    begin
      if (do_ctrl)
        ctrl_reg[rsc_pkg::CTL_WR_W-1:0] <=
          data[rsc_pkg::CTL_WR_W-1:0];
      if (store_done)
        ctrl_reg[rsc_pkg::CTL_OK] <= 1'b1;
      else if (do_store)
        ctrl_reg[rsc_pkg::CTL_OK] <= 1'b0;
    end
  end

  // Shutdown; software reset also brings the part back
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      shdn_reg <= 1'b0;
    else if (clk_en)
    begin
      if (do_shdn)
        shdn_reg <= data[0];
      else if (do_reset)
        shdn_reg <= 1'b0;
    end
  end

  // Store engine; the write lands at the end of the busy time
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      busy_cnt_reg <= '0;
    else if (clk_en)
    begin
      if (do_store)
        busy_cnt_reg <= BUSY_LOAD;
      else if (busy)
        busy_cnt_reg <= busy_cnt_reg - BUSY_ONE;
    end
  end

  // Fuse array; each location written once, in order
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      fuse_cnt_reg <= '0;
      for (int i = 0; i <= rsc_pkg::FUSE_DEPTH; i++)
        fuse_mem[i] <= '0;
    end
    else if (clk_en && store_done)
    begin
      fuse_mem[next_addr] <= wiper_reg;
      fuse_cnt_reg <= next_addr;
    end
  end

  // APB slave; answers one cycle after setup
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      link_en_reg <= rsc_pkg::LINK_EN_RST;
    end
    else if (clk_en)
    begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~hit_any;
      if (setup)
        prdata_reg <= rd_mux;
      // Only the link gate is writable; others ignore writes
      if (wr_en && hit_link)
        link_en_reg <= pwdata[rsc_pkg::LINK_EN_BIT];
    end
  end

  // Outputs straight from flip-flops; serial_out tied low
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign serial_out = 1'b0;
  assign serial_out_oe = so_oe_reg;
  assign wiper_position = wiper_reg;
  assign shutdown = shdn_reg;
  assign tolerance_calibration_off = ctrl_reg[rsc_pkg::CTL_TOL];

endmodule // rsc_top

/* File: verification/rsc_checker.sv */
// Port timing checker for the rheostat serial command block
module rsc_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sync_n,
  input wire logic serial_out_oe,
  input wire logic [9:0] wiper_position,
  input wire logic shutdown,
  input wire logic tolerance_calibration_off
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // Bus setup phase
  sequence setup_s;
    psel && !penable;
  endsequence
  // Select idle long enough for earlier effects to land
  sequence quiet_s;
    sync_n [*8];
  endsequence
  // Mid frame, no decode may happen yet
  sequence busy_frame_s;
    !sync_n [*8];
  endsequence
  bus_answer_a: assert property (setup_s |=> pready)
    else $error("no answer after setup");
  bus_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  bus_unmapped_a: assert property (setup_s ##0 paddr > 12'h00c |=> pslverr)
    else $error("unmapped access not refused");
  bus_errdata_a: assert property (pslverr |-> pready && prdata == '0)
    else $error("error answer malformed");
  power_up_a: assert property (
    $rose(rst_n) |-> wiper_position == 10'h200 && !shutdown
      ##1 wiper_position == 10'h200)
    else $error("wiper not midscale after reset");
  frame_hold_a: assert property (busy_frame_s |=> $stable(wiper_position))
    else $error("wiper moved inside a frame");
  wiper_cause_a: assert property (!$stable(wiper_position) |-> sync_n)
    else $error("wiper moved while selected");
  shdn_cause_a: assert property (!$stable(shutdown) |-> sync_n)
    else $error("shutdown moved while selected");
  tol_cause_a: assert property (
    !$stable(tolerance_calibration_off) |-> sync_n)
    else $error("control moved while selected");
  idle_release_a: assert property (quiet_s |-> !serial_out_oe)
    else $error("output driven outside a frame");
endmodule // rsc_checker

bind rsc_top rsc_checker chk (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .sync_n(sync_n),
  .serial_out_oe(serial_out_oe),
  .wiper_position(wiper_position),
  .shutdown(shutdown),
  .tolerance_calibration_off(tolerance_calibration_off)
);

/* File: verification/rsc_host.sv */
// Serial host model: sends frames and captures readback
module rsc_host (
  input wire logic ref_clk,
  output logic sync_n,
  output logic sclk,
  output logic din,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // Half period of the link clock in ref_clk cycles, 800 ns period
  localparam int HALF = 4;
  // Open-drain line, pull-up when released
  wire line = serial_out_oe ? serial_out : 1'b1;
  // Deselected, clock parked high between frames
  initial
  begin
    sync_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  // Shift n bits MSB first; sample line late in each high phase
  // All pins move just after a rising ref_clk edge
  task automatic xfer(input logic [31:0] w, input int n,
                      output logic [31:0] rd);
    rd = '0;
    @(posedge ref_clk);
    sync_n <= 1'b0;
    repeat (HALF) @(posedge ref_clk);
    for (int i = n - 1; i >= 0; i--)
    begin
      din <= w[i];
      repeat (HALF) @(posedge ref_clk);
      rd = {rd[30:0], line};
      sclk <= 1'b0;
      repeat (HALF) @(posedge ref_clk);
      sclk <= 1'b1;
    end
    repeat (HALF) @(posedge ref_clk);
    sync_n <= 1'b1;
    // Released data line must not keep its last bit
    din <= ~din;
    // Select stays high well over 8 cycles between frames
    repeat (10) @(posedge ref_clk);
  endtask
endmodule // rsc_host

/* File: verification/tb.sv */
// Testbench for the rheostat serial command block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, rst_n, psel, penable, pwrite, err, got;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rw;
  logic pready, pslverr, sync_n, sclk, din, so, so_oe, shdn, tol;
  logic [9:0] wiper;
  logic [9:0] wiper_s; // Wiper of the 256-position instance
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  rsc_top #(.STORE_CYCLES(300), .SHORT_VARIANT(1'b0)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_n(sync_n), .sclk(sclk), .din(din), .serial_out(so),
    .serial_out_oe(so_oe), .wiper_position(wiper), .shutdown(shdn),
    .tolerance_calibration_off(tol));
  // Short variant shares the bus and pins; only its wiper is watched
  rsc_top #(.STORE_CYCLES(300), .SHORT_VARIANT(1'b1)) dut_short (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(), .pready(), .pslverr(), .sync_n(sync_n), .sclk(sclk),
    .din(din), .serial_out(), .serial_out_oe(),
    .wiper_position(wiper_s), .shutdown(),
    .tolerance_calibration_off());
  rsc_host host (.ref_clk(ref_clk), .sync_n(sync_n), .sclk(sclk),
    .din(din), .serial_out(so), .serial_out_oe(so_oe));
  // 10 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; answer taken at the edge seeing pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Request holds until a rising edge samples pready high
    do
    begin
      @(posedge ref_clk);
      got = pready;
    end while (got !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [11:0] a,
                       input logic [15:0] exp);
    apb(1'b0, a, '0);
    check(what, rd[15:0], exp);
  endtask
  task automatic frame(input logic [15:0] w);
    host.xfer({16'h0000, w}, 16, rw);
  endtask
  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rdchk("status", rsc_pkg::OFS_STATUS, 16'h0000);
    rdchk("wiper", rsc_pkg::OFS_WIPER, 16'h0200);
    rdchk("unmapped", 12'h010, 16'h0000);
    check("slverr", 16'(err), 16'h0001);
    rdchk("link", rsc_pkg::OFS_LINK, 16'h0001);
    frame(16'h0500);
    check("locked", 16'(wiper), 16'h0200);
    frame(16'h1C03);
    check("echo", rw[15:0], 16'h0500);
    rdchk("ctrl", rsc_pkg::OFS_STATUS, 16'h0003);
    frame(16'h0500);
    check("unlocked", 16'(wiper), 16'h0100);
    frame(16'h0800);
    frame(16'h0000);
    check("rd wiper", 16'(rw[9:0]), 16'h0100);
    host.xfer(32'h0000_07FF, 12, rw);
    check("partial", 16'(wiper), 16'h0100);
    host.xfer(32'h0000_07FF, 17, rw);
    check("17 bits", 16'(wiper), 16'h0100);
    host.xfer(32'h07FF_0580, 32, rw);
    check("32 bits", 16'(wiper), 16'h0180);
    // Link disabled: frames must be dropped
    apb(1'b1, rsc_pkg::OFS_LINK, 32'h0000_0000);
    frame(16'h2401);
    check("link off", 16'(shdn), 16'h0000);
    apb(1'b1, rsc_pkg::OFS_LINK, 32'h0000_0001);
    frame(16'h2401);
    rdchk("shdn", rsc_pkg::OFS_STATUS, 16'h0403);
    frame(16'h2400);
    check("wake", 16'(shdn), 16'h0000);
    frame(16'h0C00);
    rdchk("busy", rsc_pkg::OFS_STATUS, 16'h0803);
    frame(16'h0440);
    check("locked store", 16'(wiper), 16'h0180);
    // Poll until the store finishes
    do
    begin
      apb(1'b0, rsc_pkg::OFS_STATUS, '0);
    end while (rd[11] !== 1'b0);
    rdchk("stored", rsc_pkg::OFS_STATUS, 16'h001B);
    frame(16'h1C02);
    frame(16'h0440);
    frame(16'h0C00);
    rdchk("no store", rsc_pkg::OFS_STATUS, 16'h001A);
    frame(16'h1000);
    check("sw reset", 16'(wiper), 16'h0180);
    frame(16'h1800);
    frame(16'h1401);
    check("last addr", 16'(rw[5:0]), 16'h0001);
    frame(16'h2000);
    check("fuse", 16'(rw[9:0]), 16'h0180);
    frame(16'h1C06);
    check("ctrl rd", 16'(rw[3:0]), 16'h000A);
    check("tol", 16'(tol), 16'h0001);
    frame(16'h0403);
    check("wiper lsb", 16'(wiper), 16'h0003);
    check("short lsb", 16'(wiper_s), 16'h0000);
    // Second reset in mid run
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check("reset wiper", 16'(wiper), 16'h0200);
    rdchk("reset ctrl", rsc_pkg::OFS_STATUS, 16'h0000);
    complete_run();
  end
endmodule // tb
